// *** inc/spss_map.vh ***
`ifndef SPSS_MAP_VH
`define SPSS_MAP_VH
`define SPSS_REG_REVISION  8'h00
`define SPSS_REG_STATUS    8'h01
`define SPSS_REG_GENERAL   8'h05
`define SPSS_STATUS_RESET  16'h0000
`define SPSS_ST_SHUTDOWN   5'h00
`define SPSS_ST_OFF        5'h02
`define SPSS_ST_RAIL11     5'h04
`define SPSS_ST_RAIL18     5'h05
`define SPSS_ST_RAIL33     5'h06
`define SPSS_ST_RESETHOLD  5'h07
`define SPSS_ST_STANDBY    5'h08
`define SPSS_ST_MIRRORUP   5'h09
`define SPSS_ST_READY      5'h0c
`define SPSS_ST_DISPLAY    5'h0d
`define SPSS_ST_PARKINIT   5'h0e
`define SPSS_ST_PARKRAILS  5'h0f
`define SPSS_ST_DISCHARGE  5'h11
`define SPSS_CAUSE_POWERON 3'h0
`define SPSS_CAUSE_ENLOW   3'h1
`define SPSS_CAUSE_WD1     3'h2
`define SPSS_CAUSE_WD2     3'h3
`define SPSS_CAUSE_HOT     3'h4
`define SPSS_CAUSE_SWCYCLE 3'h5
`define SPSS_BIT_ENLOW     0
`define SPSS_BIT_HOTERR    1
`define SPSS_BIT_HOTWARN   2
`define SPSS_BIT_RAILFAULT 3
`define SPSS_BIT_CHANGE    5
`define SPSS_BIT_WD1       6
`define SPSS_BIT_WD2       7
`define SPSS_BIT_ADCERR    11
`define SPSS_BIT_PARITY    12
`define SPSS_BIT_RAILTIMER 13
`define SPSS_BIT_PGFAULT   15
`define SPSS_STICKY_MASK   16'h30e8
`define SPSS_RESET_HOLD_NS 20000
`define SPSS_PARK_STEP_NS  10000
`define SPSS_CLK_NS        4
`endif

// *** hdl/spss_sequencer.v ***
`timescale 1ns/10ps
`default_nettype none
`include "spss_map.vh"

// Top-level operating-state sequencer.
//
// States, in the order a clean power-up meets them:
// OFF, three rail steps, reset hold, STANDBY,
// mirror power-up, display ready, DISPLAY.
// Parking takes three timed steps back to STANDBY.
// SHUTDOWN is the dead end for a hot die.
// topState carries the same code that the general
// status register shows in its low five bits.
//
// Power-up.
// OFF is left only with a good main supply, the
// projector enable high and no heat warning.
// One rail comes on per clock, lowest voltage first,
// so a later rail never leads an earlier one.
// The third step then waits, with no time limit,
// for all four rail monitors to report in range.
// A stuck monitor therefore holds the sequence
// there; software sees it in the state code.
//
// Controller reset.
// The reset output is low in SHUTDOWN and in every
// state before STANDBY, high elsewhere. With good
// rails it stays low for RESET_HOLD_CYC + 1 more
// clocks, so the controller never boots on rails
// that are still settling.
//
// Software steps.
// The display controller moves the mirrors with
// three pulses: start mirror power-up, confirm the
// mirror array, turn the illumination on. A pulse
// counts only in the state that expects it; a stray
// pulse elsewhere is dropped, not remembered.
//
// Parking.
// In display ready and DISPLAY any park event
// starts the walk. Each step lasts PARK_STEP_CYC + 1
// clocks. The mirror regulators go off after the
// first step and the walk ends in STANDBY with the
// external rails still up, ready for a quick restart.
//
// Faults.
// A hot die in STANDBY goes straight to SHUTDOWN,
// where all rails are off; only enable low exits.
// The same error holds the park output low in any
// state; nothing masks it. Other STANDBY faults go
// back to OFF and leave a 3-bit cause code.
//
// Status.
// Event bits stick until software writes a one to
// them; a new event in the clearing cycle wins, so
// no event is lost. Level bits follow their inputs
// and cannot be cleared.
//
// Limitations.
// Enable low is ignored while rails and mirrors
// come up, so a half-done sequence is never cut;
// the reaction comes once the sequence has ended.
// The reset is synchronous and needs a clock edge.
// One timer serves the hold and the park steps;
// they never overlap, so sharing costs nothing.
module spss_sequencer #(
    parameter [7:0]  REV_MAJOR_MINOR = 8'h11, // Arbitrary revision value.
    // Timing counts are in clocks, rounded up from ns.
    parameter [15:0] RESET_HOLD_CYC  = (`SPSS_RESET_HOLD_NS + `SPSS_CLK_NS - 1) / `SPSS_CLK_NS,
    parameter [15:0] PARK_STEP_CYC   = (`SPSS_PARK_STEP_NS + `SPSS_CLK_NS - 1) / `SPSS_CLK_NS
) (
    // Clock and reset.
    input  wire        sys_clk,
    input  wire        sys_rst,

    // Monitors and pins.
    input  wire        main_supply_monitor,
    input  wire        projector_enable_in,
    input  wire        hotWarn,
    input  wire        hotError,
    input  wire [3:0]  railGood,
    input  wire        wd1Error,
    input  wire        wd2Error,
    input  wire        wdEnable,
    input  wire        mirrorRailFault,
    input  wire        mirrorRailTimer,
    input  wire [15:0] pgFaultReg,
    input  wire [7:0]  adcStatusReg,
    input  wire        parityError,

    // Software events from the display controller.
    input  wire        swMirrorEnable,
    input  wire        swMirrorGood,
    input  wire        swIllumEnable,
    input  wire        swPark,
    input  wire        swPowerCycle,

    // Register port.
    input  wire [7:0]  regAddr,
    input  wire        regWrite,
    input  wire [15:0] regWdata,
    output reg  [15:0] regRdata,

    // Supply and controller outputs.
    output reg         rail11En,
    output reg         rail18En,
    output reg         rail33En,
    output reg         mirrorRegEn,
    output reg         controller_reset_n,
    output reg         park_request_n,
    output reg  [4:0]  topState,
    output reg  [2:0]  lastCause
);

    // Working state of the sequencer.
    reg  [15:0] timer;        // Shared countdown for hold and park steps.
    reg  [4:0]  next_state;   // Combinational next state.
    reg  [2:0]  next_cause;   // Cause latched when OFF is entered.
    reg  [15:0] stickyBits;   // Hardware-set, write-one-to-clear bits.
    wire        powerGood;    // Supply and all four rail monitors together.
    wire        parkEvent;    // Any reason to park the mirrors.
    wire        allRails;     // All four rail monitors in range.
    wire [15:0] statusView;   // Assembled status word.

    assign allRails  = &railGood;
    assign powerGood = main_supply_monitor & allRails;
    // Park events in ready and display alike.
    assign parkEvent = ~powerGood | ~projector_enable_in | hotError | swPark | swPowerCycle;

    // Next-state decision; an exit depends on the current state, the inputs and the timer.
    always @* begin
        next_state = topState;
        next_cause = lastCause;
        case (topState)
            // Heat warning alone keeps OFF; no rail moves.
            `SPSS_ST_OFF: begin
                if (main_supply_monitor && projector_enable_in && !hotWarn) begin
                    next_state = `SPSS_ST_RAIL11;
                end
            end
            // Power-on ignores enable low until STANDBY is reached.
            `SPSS_ST_RAIL11: next_state = `SPSS_ST_RAIL18;
            `SPSS_ST_RAIL18: next_state = `SPSS_ST_RAIL33;

            // Third rail on; wait for every monitor.
            `SPSS_ST_RAIL33: begin
                if (allRails) begin
                    next_state = `SPSS_ST_RESETHOLD;
                end
            end

            // Timer loaded on entry; zero ends the hold.
            `SPSS_ST_RESETHOLD: begin
                if (timer == 16'h0000) begin
                    next_state = `SPSS_ST_STANDBY;
                end
            end

            // Heat outranks the rest: a hot die must not
            // restart the rails. Exits are ranked so that
            // exactly one cause code is recorded.
            `SPSS_ST_STANDBY: begin
                if (hotError) begin
                    next_state = `SPSS_ST_SHUTDOWN;
                end else if (!projector_enable_in) begin
                    next_state = `SPSS_ST_OFF;
                    next_cause = `SPSS_CAUSE_ENLOW;
                end else if (swPowerCycle) begin
                    next_state = `SPSS_ST_OFF;
                    next_cause = `SPSS_CAUSE_SWCYCLE;
                end else if (wdEnable && wd1Error) begin
                    next_state = `SPSS_ST_OFF;
                    next_cause = `SPSS_CAUSE_WD1;
                end else if (wdEnable && wd2Error) begin
                    next_state = `SPSS_ST_OFF;
                    next_cause = `SPSS_CAUSE_WD2;
                end else if (!powerGood) begin
                    next_state = `SPSS_ST_OFF;
                    next_cause = `SPSS_CAUSE_POWERON;
                end else if (swMirrorEnable) begin
                    next_state = `SPSS_ST_MIRRORUP;
                end
            end

            // Mirror power-up completes even if enable drops.
            `SPSS_ST_MIRRORUP: begin
                if (swMirrorGood) begin
                    next_state = `SPSS_ST_READY;
                end
            end

            // A park event outranks an illumination request.
            `SPSS_ST_READY: begin
                if (parkEvent) begin
                    next_state = `SPSS_ST_PARKINIT;
                end else if (swIllumEnable) begin
                    next_state = `SPSS_ST_DISPLAY;
                end
            end

            // Only a park event leaves DISPLAY.
            `SPSS_ST_DISPLAY: begin
                if (parkEvent) begin
                    next_state = `SPSS_ST_PARKINIT;
                end
            end

            // Three parking steps, each timed from entry.
            `SPSS_ST_PARKINIT: begin
                if (timer == 16'h0000) begin
                    next_state = `SPSS_ST_PARKRAILS;
                end
            end
            `SPSS_ST_PARKRAILS: begin
                if (timer == 16'h0000) begin
                    next_state = `SPSS_ST_DISCHARGE;
                end
            end
            `SPSS_ST_DISCHARGE: begin
                if (timer == 16'h0000) begin
                    next_state = `SPSS_ST_STANDBY;
                end
            end

            // A cool die is not enough; enable must drop.
            `SPSS_ST_SHUTDOWN: begin
                if (!projector_enable_in) begin
                    next_state = `SPSS_ST_OFF;
                    next_cause = `SPSS_CAUSE_HOT;
                end
            end

            // Unused codes fall back to OFF, never hang.
            default: next_state = `SPSS_ST_OFF;
        endcase
    end

    // State, timer and supply outputs.
    // Reset is synchronous; every output is a flop.
    // Outputs decode next_state so they change on
    // the same edge as topState, never a clock late.
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            topState           <= `SPSS_ST_OFF;
            lastCause          <= `SPSS_CAUSE_POWERON;
            timer              <= 16'h0000;
            rail11En           <= 1'b0;
            rail18En           <= 1'b0;
            rail33En           <= 1'b0;
            mirrorRegEn        <= 1'b0;
            controller_reset_n <= 1'b0;
            park_request_n     <= 1'b1;
        end else begin
            topState  <= next_state;
            lastCause <= next_cause;

            // Reload the timer on entry to a timed state, else count down.
            // Untimed states load it too and simply ignore it.
            if (next_state != topState) begin
                timer <= (next_state == `SPSS_ST_RESETHOLD) ? RESET_HOLD_CYC : PARK_STEP_CYC;
            end else if (timer != 16'h0000) begin
                timer <= timer - 16'h0001;
            end

            // Rails build up in order and stay on until OFF or SHUTDOWN.
            // Parking leaves them up for a quick restart.
            case (next_state)
                `SPSS_ST_OFF, `SPSS_ST_SHUTDOWN: begin
                    rail11En <= 1'b0;
                    rail18En <= 1'b0;
                    rail33En <= 1'b0;
                end
                `SPSS_ST_RAIL11: rail11En <= 1'b1;
                `SPSS_ST_RAIL18: rail18En <= 1'b1;
                `SPSS_ST_RAIL33: rail33En <= 1'b1;
                default: rail11En <= rail11En;
            endcase

            // Controller reset low in SHUTDOWN and in every state before STANDBY.
            controller_reset_n <= !(next_state == `SPSS_ST_OFF || next_state == `SPSS_ST_SHUTDOWN
                || next_state == `SPSS_ST_RAIL11 || next_state == `SPSS_ST_RAIL18
                || next_state == `SPSS_ST_RAIL33 || next_state == `SPSS_ST_RESETHOLD);

            // Mirror regulators run from power-up until park disables them.
            // They are never on while the rails are still rising.
            mirrorRegEn <= (next_state == `SPSS_ST_MIRRORUP) || (next_state == `SPSS_ST_READY)
                || (next_state == `SPSS_ST_DISPLAY) || (next_state == `SPSS_ST_PARKINIT);
            // Park low while parking; over-temperature error cannot be masked.
            park_request_n <= !((next_state == `SPSS_ST_PARKINIT)
                || (next_state == `SPSS_ST_PARKRAILS)
                || (next_state == `SPSS_ST_DISCHARGE) || hotError);
        end
    end

    // Sticky events: a new event wins over a clear in the same cycle.
    // The mask keeps software from clearing level bits.
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            stickyBits <= `SPSS_STATUS_RESET;
        end else begin
            stickyBits <= (stickyBits & ~((regWrite && regAddr == `SPSS_REG_STATUS) ?
                (regWdata & `SPSS_STICKY_MASK) : 16'h0000))
                | ({15'h0000, parityError} << `SPSS_BIT_PARITY)
                | ({15'h0000, mirrorRailFault} << `SPSS_BIT_RAILFAULT)
                | ({15'h0000, mirrorRailTimer} << `SPSS_BIT_RAILTIMER)
                | ({15'h0000, wd1Error} << `SPSS_BIT_WD1)
                | ({15'h0000, wd2Error} << `SPSS_BIT_WD2)
                | ({15'h0000, (next_state != topState)} << `SPSS_BIT_CHANGE);
        end
    end

    // Live bits are merged into the sticky word.
    // They follow their inputs and ignore writes.
    assign statusView = stickyBits
        | ({15'h0000, (|pgFaultReg)} << `SPSS_BIT_PGFAULT)
        | ({15'h0000, (|adcStatusReg)} << `SPSS_BIT_ADCERR)
        | ({15'h0000, hotWarn} << `SPSS_BIT_HOTWARN)
        | ({15'h0000, hotError} << `SPSS_BIT_HOTERR)
        | ({15'h0000, !projector_enable_in} << `SPSS_BIT_ENLOW);

    // Registered read data; unmapped addresses read zero.
    // Data is one clock behind the address.
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            regRdata <= 16'h0000;
        end else begin
            case (regAddr)
                `SPSS_REG_REVISION: regRdata <= {8'h00, REV_MAJOR_MINOR};
                `SPSS_REG_STATUS:   regRdata <= statusView;
                `SPSS_REG_GENERAL:  regRdata <= {8'h00, lastCause, topState};
                default:            regRdata <= 16'h0000;
            endcase
        end
    end

endmodule
`default_nettype wire

// *** sim/spss_sequencer_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "spss_map.vh"
// Port checker for the sequencer, written for hold and park counts of four.
module spss_sequencer_asserts (
    // Clock and reset.
    input wire logic       sys_clk,
    input wire logic       sys_rst,
    // Inputs that cause transitions.
    input wire logic       main_supply_monitor,
    input wire logic       projector_enable_in,
    input wire logic       hotWarn,
    input wire logic       hotError,
    input wire logic [3:0] railGood,
    input wire logic       swPark,
    // Outputs under watch.
    input wire logic       rail11En,
    input wire logic       rail18En,
    input wire logic       rail33En,
    input wire logic       controller_reset_n,
    input wire logic       park_request_n,
    input wire logic [4:0] topState
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // The three parking steps all hold the park output low.
    wire logic inPark = topState inside {`SPSS_ST_PARKINIT, `SPSS_ST_PARKRAILS, `SPSS_ST_DISCHARGE};
    // Display states react to park events the same way.
    wire logic inShow = topState == `SPSS_ST_READY || topState == `SPSS_ST_DISPLAY;
    a_off_exit_gate: assert property (topState == `SPSS_ST_OFF && !(main_supply_monitor &&
        projector_enable_in && !hotWarn) |=> topState == `SPSS_ST_OFF) else $error("left OFF early");
    a_rail_order: assert property (topState == `SPSS_ST_RAIL18 |->
        rail11En && rail18En && !rail33En) else $error("rail order wrong");
    a_rails_wait: assert property (topState == `SPSS_ST_RAIL33 && railGood != 4'hf
        |=> topState == `SPSS_ST_RAIL33) else $error("left rail wait early");
    a_reset_hold: assert property ($rose(topState == `SPSS_ST_RESETHOLD) |->
        !controller_reset_n [*4] ##[1:4] (topState == `SPSS_ST_STANDBY && controller_reset_n))
        else $error("reset hold wrong");
    a_hot_shutdown: assert property (topState == `SPSS_ST_STANDBY && hotError &&
        projector_enable_in && main_supply_monitor |=> topState == `SPSS_ST_SHUTDOWN)
        else $error("no shutdown on heat");
    a_standby_off: assert property (topState == `SPSS_ST_STANDBY && !projector_enable_in
        && !hotError |=> topState == `SPSS_ST_OFF) else $error("standby did not drop");
    a_park_entry: assert property (inShow && (swPark || !projector_enable_in)
        |=> topState == `SPSS_ST_PARKINIT) else $error("park event ignored");
    a_park_low: assert property (inPark |-> !park_request_n)
        else $error("park output high while parking");
    a_hot_park: assert property (hotError |=> !park_request_n)
        else $error("heat did not park");
    a_shutdown_dark: assert property (topState == `SPSS_ST_SHUTDOWN |->
        !(rail11En || rail18En || rail33En)) else $error("rails on in shutdown");
endmodule
bind spss_sequencer spss_sequencer_asserts u_chk (.sys_clk, .sys_rst, .main_supply_monitor,
    .projector_enable_in, .hotWarn, .hotError, .railGood, .swPark, .rail11En, .rail18En,
    .rail33En, .controller_reset_n, .park_request_n, .topState);
`default_nettype wire

// *** sim/spss_ctrl_model.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "spss_map.vh"
// Software of the display controller stepping the mirror power-up once booted.
module spss_ctrl_model (
    input  wire logic       sys_clk,
    input  wire logic       run,
    input  wire logic       controller_reset_n,
    input  wire logic [4:0] topState,
    output logic            swMirrorEnable = 1'b0,
    output logic            swMirrorGood = 1'b0,
    output logic            swIllumEnable = 1'b0
);
    logic [4:0] lastState = 5'h1f; // State seen at the previous edge.
    logic [3:0] dwell = 4'h0;      // Cycles spent in the current state.
    wire logic  act = run && controller_reset_n && dwell == 4'h3; // Software latency of 3.
    // Each command is a single pulse; a slow reply keeps the sequencer waiting.
    always @(posedge sys_clk) begin
        lastState <= topState;
        dwell <= (topState != lastState) ? 4'h0 : dwell + 4'h1;
        swMirrorEnable <= act && topState == `SPSS_ST_STANDBY;
        swMirrorGood <= act && topState == `SPSS_ST_MIRRORUP;
        swIllumEnable <= act && topState == `SPSS_ST_READY;
    end
endmodule
`default_nettype wire

// *** sim/spss_sequencer_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "spss_map.vh"
module spss_sequencer_tb;
    logic        sys_clk = 1'b0, sys_rst = 1'b1, run = 1'b0, swPark = 1'b0, swPowerCycle = 1'b0;
    logic        wd1Error = 1'b0, wd2Error = 1'b0, wdEnable = 1'b0, mirrorRailTimer = 1'b0;
    logic        main_supply_monitor = 1'b1, projector_enable_in = 1'b0, hotWarn = 1'b0;
    logic        hotError = 1'b0, parityError = 1'b0, mirrorRailFault = 1'b0, regWrite = 1'b0;
    logic [3:0]  railGood = 4'h0;
    logic [7:0]  adcStatusReg = 8'h00, regAddr = 8'h00;
    logic [15:0] pgFaultReg = 16'h0000, regWdata = 16'h0000, regRdata, d;
    logic        rail11En, rail18En, rail33En, mirrorRegEn, controller_reset_n, park_request_n;
    logic        swMirrorEnable, swMirrorGood, swIllumEnable;
    logic [4:0]  topState;
    logic [2:0]  lastCause;
    int          err_count = 0, total_checks = 0, cycles = 0;
    // Short hold and park counts keep the run brief.
    spss_sequencer #(.REV_MAJOR_MINOR(8'h35), .RESET_HOLD_CYC(16'h0004),
        .PARK_STEP_CYC(16'h0004)) u_dut (.sys_clk, .sys_rst, .main_supply_monitor,
        .projector_enable_in, .hotWarn, .hotError, .railGood, .wd1Error, .wd2Error,
        .wdEnable, .mirrorRailFault, .mirrorRailTimer, .pgFaultReg, .adcStatusReg,
        .parityError, .swMirrorEnable, .swMirrorGood, .swIllumEnable, .swPark,
        .swPowerCycle, .regAddr, .regWrite, .regWdata, .regRdata, .rail11En, .rail18En,
        .rail33En, .mirrorRegEn, .controller_reset_n, .park_request_n, .topState, .lastCause);
    spss_ctrl_model u_ctrl (.sys_clk, .run, .controller_reset_n, .topState, .swMirrorEnable,
        .swMirrorGood, .swIllumEnable);
    // The clock toggles every 2 ns for a 4 ns period.
    initial begin
        forever #2 sys_clk = ~sys_clk;
    end
    // Prints the counts and the verdict, then stops.
    task automatic end_sim;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Compares a value against its expectation and counts the outcome.
    task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Register reads return data one cycle after the address is presented.
    task automatic rd(input logic [7:0] a);
        @(negedge sys_clk) regAddr = a;
        @(negedge sys_clk) d = regRdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(negedge sys_clk) begin
            regAddr = a;
            regWdata = v;
            regWrite = 1'b1;
        end
        @(negedge sys_clk) regWrite = 1'b0;
    endtask
    // Waits a bounded time for a state, then checks that it was reached.
    task automatic wst(input logic [4:0] s);
        int n;
        n = 0;
        while (topState !== s && n < 100) begin
            @(negedge sys_clk);
            n++;
        end
        chk("topState", {11'h0, topState}, {11'h0, s});
    endtask
    // A hang is cut short after far more cycles than the sequence needs.
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            end_sim();
        end
    end
    initial begin
        repeat (8) @(negedge sys_clk);
        chk("offPins", {10'h0, rail11En, rail18En, rail33En, mirrorRegEn, controller_reset_n,
            park_request_n}, 16'h0001);
        sys_rst = 1'b0;
        rd(`SPSS_REG_STATUS);
        chk("status", d, 16'h0001);
        wr(`SPSS_REG_REVISION, 16'hffff);
        rd(`SPSS_REG_REVISION);
        chk("revision", d, 16'h0035);
        hotWarn = 1'b1;
        projector_enable_in = 1'b1;
        repeat (5) @(negedge sys_clk);
        chk("warmOff", {11'h0, topState}, {11'h0, `SPSS_ST_OFF});
        hotWarn = 1'b0;
        wst(`SPSS_ST_RAIL11);
        chk("rails", {13'h0, rail11En, rail18En, rail33En}, 16'h0004);
        wst(`SPSS_ST_RAIL18);
        chk("rails", {13'h0, rail11En, rail18En, rail33En}, 16'h0006);
        wst(`SPSS_ST_RAIL33);
        repeat (5) @(negedge sys_clk);
        chk("railWait", {11'h0, topState}, {11'h0, `SPSS_ST_RAIL33});
        railGood = 4'hf;
        wst(`SPSS_ST_RESETHOLD);
        chk("resetLow", {15'h0, controller_reset_n}, 16'h0000);
        wst(`SPSS_ST_STANDBY);
        chk("resetHigh", {15'h0, controller_reset_n}, 16'h0001);
        parityError = 1'b1;
        mirrorRailFault = 1'b1;
        mirrorRailTimer = 1'b1;
        wd2Error = 1'b1;
        hotWarn = 1'b1;
        pgFaultReg = 16'h0100;
        adcStatusReg = 8'h10;
        @(negedge sys_clk) begin
            parityError = 1'b0;
            mirrorRailFault = 1'b0;
            mirrorRailTimer = 1'b0;
            wd2Error = 1'b0;
        end
        rd(`SPSS_REG_STATUS);
        chk("events", d & 16'hb8af, 16'hb8ac);
        chk("wdGated", {11'h0, topState}, {11'h0, `SPSS_ST_STANDBY});
        hotWarn = 1'b0;
        pgFaultReg = 16'h0000;
        adcStatusReg = 8'h00;
        wr(`SPSS_REG_STATUS, 16'hffff);
        rd(`SPSS_REG_STATUS);
        chk("cleared", d, 16'h0000);
        run = 1'b1;
        wst(`SPSS_ST_MIRRORUP);
        wst(`SPSS_ST_READY);
        wst(`SPSS_ST_DISPLAY);
        chk("mirrorOn", {15'h0, mirrorRegEn}, 16'h0001);
        run = 1'b0;
        @(negedge sys_clk) swPark = 1'b1;
        @(negedge sys_clk) swPark = 1'b0;
        wst(`SPSS_ST_PARKINIT);
        chk("parkLow", {15'h0, park_request_n}, 16'h0000);
        wst(`SPSS_ST_STANDBY);
        chk("mirrorOff", {15'h0, mirrorRegEn}, 16'h0000);
        projector_enable_in = 1'b0;
        wst(`SPSS_ST_OFF);
        chk("cause", {13'h0, lastCause}, {13'h0, `SPSS_CAUSE_ENLOW});
        rd(`SPSS_REG_GENERAL);
        chk("general", d, {8'h00, `SPSS_CAUSE_ENLOW, `SPSS_ST_OFF});
        projector_enable_in = 1'b1;
        wst(`SPSS_ST_STANDBY);
        wdEnable = 1'b1;
        wd1Error = 1'b1;
        @(negedge sys_clk) wd1Error = 1'b0;
        wst(`SPSS_ST_OFF);
        chk("cause", {13'h0, lastCause}, {13'h0, `SPSS_CAUSE_WD1});
        wst(`SPSS_ST_STANDBY);
        swPowerCycle = 1'b1;
        @(negedge sys_clk) swPowerCycle = 1'b0;
        wst(`SPSS_ST_OFF);
        chk("cause", {13'h0, lastCause}, {13'h0, `SPSS_CAUSE_SWCYCLE});
        wst(`SPSS_ST_STANDBY);
        main_supply_monitor = 1'b0;
        wst(`SPSS_ST_OFF);
        chk("cause", {13'h0, lastCause}, {13'h0, `SPSS_CAUSE_POWERON});
        main_supply_monitor = 1'b1;
        wst(`SPSS_ST_STANDBY);
        hotError = 1'b1;
        wst(`SPSS_ST_SHUTDOWN);
        chk("dark", {12'h0, rail11En, rail18En, rail33En, park_request_n}, 16'h0000);
        rd(`SPSS_REG_STATUS);
        chk("hotBit", d & 16'h0002, 16'h0002);
        hotError = 1'b0;
        repeat (5) @(negedge sys_clk);
        chk("stayShut", {11'h0, topState}, {11'h0, `SPSS_ST_SHUTDOWN});
        projector_enable_in = 1'b0;
        wst(`SPSS_ST_OFF);
        chk("cause", {13'h0, lastCause}, {13'h0, `SPSS_CAUSE_HOT});
        end_sim();
    end
endmodule
`default_nettype wire
